// ---- hw/stl_pkg.sv ----
// Package for the S/T layer-1 activation block: timing, events and state
// What this block does
// (RULE1) NT holds G0 until release, then G2
// (RULE2) NT sends INFO0 in G0/G1/G4, 2 G2, 4 G3
// (RULE3) NT activate goes G2 from G1/G4
// (RULE4) NT deactivate in G2/G3 starts T2, G4
// (RULE5) T2 lasts 256 frames, 32 ms
// (RULE6) T2 expiry in G4 goes G1
// (RULE7) NT INFO0: G3 to G2, G4 to G1
// (RULE8) NT INFO1 in G1 goes G2
// (RULE9) NT INFO3 in G2 goes G3
// (RULE10) NT lost framing in G3 goes G2
// (RULE11) Software provides timers T1 and T3
// (RULE12) TE holds F0 until release, then F2
// (RULE13) TE sends INFO1 in F4, INFO3 F6/F7, else 0
// (RULE14) TE signal: F3 activate or F4 gives F5
// (RULE15) TE activate in F3 with INFO0 gives F4
// (RULE16) TE T3 expiry: F4/F5/F6 to F3
// (RULE17) TE INFO0: F2/F6/F7/F8 to F3
// (RULE18) TE INFO2 sync goes F6
// (RULE19) TE INFO4 sync goes F7
// (RULE20) TE sync loss in F6/F7 goes F8
// (RULE21) TE Q bit in every fifth FA bit
// (RULE22) B data LSB first HDLC, MSB first PCM
// (RULE23) Events act once per frame, else no change
package stl_pkg;
	localparam int FRAME_NS = 125000;
	localparam int CLK_NS = 40;
	localparam int FRAME_CYC = FRAME_NS / CLK_NS;
	localparam int TICK_W = 12;
	localparam int T2_MS = 32;
	localparam int T2_FRAMES = 256;
	localparam int T2_W = 8;
	localparam int QS_PERIOD = 5;
	typedef enum logic [2:0] {NT_G0, NT_G1, NT_G2, NT_G3, NT_G4} stl_nt_t;
	typedef enum logic [2:0] {TE_F0, TE_F2, TE_F3, TE_F4, TE_F5, TE_F6, TE_F7, TE_F8} stl_te_t;
	typedef enum logic [2:0] {INFO_0, INFO_1, INFO_2, INFO_3, INFO_4} stl_info_t;
	typedef struct packed {
		logic rel;
		logic act;
		logic deact;
		logic t3_exp;
	} stl_cmd_t;
	typedef struct packed {
		logic info0;
		logic info1;
		logic info3;
		logic any_sig;
		logic info2_sync;
		logic info4_sync;
		logic lost;
	} stl_rx_t;
	typedef struct packed {
		logic [TICK_W-1:0] tick_cnt;
		logic [2:0] qs_cnt;
		logic [T2_W-1:0] t2_cnt;
		logic t2_run;
		stl_cmd_t pend;
		stl_nt_t nt;
		stl_te_t te;
		stl_info_t info;
		logic q_slot;
		logic fa;
		logic [7:0] b_tx;
		logic [7:0] b_rx;
	} stl_st_t;
	localparam stl_st_t ST_RST = '0;
endpackage : stl_pkg

// ---- hw/stl_act_fsm.sv ----
// S/T layer-1 activation state machines (NT and TE), FA/Q slot and B bit order
`timescale 1ns/100ps
module stl_act_fsm import stl_pkg::*; #(
	parameter int FRAME_CYCLES = FRAME_CYC,
	parameter int T2_LEN = T2_FRAMES
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic NT_MODE,
	input wire stl_cmd_t CMD,
	input wire stl_rx_t RX,
	input wire logic QS_EN,
	input wire logic Q_IN,
	input wire logic B_HDLC,
	input wire logic [7:0] B_TX_BYTE,
	input wire logic [7:0] B_LINE_RX,
	output stl_info_t TX_INFO,
	output stl_nt_t NT_STATE,
	output stl_te_t TE_STATE,
	output logic T2_RUN,
	output logic FRAME_TICK,
	output logic Q_SLOT,
	output logic FA_TX,
	output logic [7:0] B_LINE_TX,
	output logic [7:0] B_RX_BYTE
);
	stl_st_t st_reg;
	stl_st_t st_next;
	logic tick;
	logic t2_exp;
	logic [7:0] rev_tx;
	logic [7:0] rev_rx;

	assign tick = st_reg.tick_cnt == TICK_W'(FRAME_CYCLES - 1);
	assign t2_exp = st_reg.t2_run && st_reg.t2_cnt == '0;

	// Line vectors hold the first bit on the wire in bit 7
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_rev
			assign rev_tx[i] = B_TX_BYTE[7 - i];
			assign rev_rx[i] = B_LINE_RX[7 - i];
		end
	endgenerate

	always_comb begin
		st_next = st_reg;
		st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 1'b1;
		// A command arriving on the consuming edge is kept for the next frame
		st_next.pend = stl_cmd_t'((tick ? 4'h0 : st_reg.pend) | CMD);
		st_next.b_tx = B_HDLC ? rev_tx : B_TX_BYTE; // RULE22
		st_next.b_rx = B_HDLC ? rev_rx : B_LINE_RX; // RULE22
		if (tick) begin // RULE23
			if (st_reg.t2_run) begin
				if (t2_exp) begin
					st_next.t2_run = 1'b0;
				end else begin
					st_next.t2_cnt = st_reg.t2_cnt - 1'b1; // RULE5
				end
			end
			if (!NT_MODE) begin
				st_next.nt = NT_G0;
				st_next.t2_run = 1'b0;
			end else begin
				unique case (st_reg.nt)
					NT_G0: begin
						if (st_reg.pend.rel) begin
							st_next.nt = NT_G2; // RULE1
						end
					end
					NT_G1: begin
						if (st_reg.pend.act || RX.info1) begin
							st_next.nt = NT_G2; // RULE3 RULE8
						end
					end
					NT_G2: begin
						if (st_reg.pend.deact) begin
							st_next.nt = NT_G4; // RULE4
							st_next.t2_run = 1'b1;
							st_next.t2_cnt = T2_W'(T2_LEN - 1); // RULE5
						end else if (RX.info3) begin
							st_next.nt = NT_G3; // RULE9
						end
					end
					NT_G3: begin
						if (st_reg.pend.deact) begin
							st_next.nt = NT_G4; // RULE4
							st_next.t2_run = 1'b1;
							st_next.t2_cnt = T2_W'(T2_LEN - 1); // RULE5
						end else if (RX.info0 || RX.lost) begin
							st_next.nt = NT_G2; // RULE7 RULE10
						end
					end
					NT_G4: begin
						if (t2_exp || RX.info0) begin
							st_next.nt = NT_G1; // RULE6 RULE7
							st_next.t2_run = 1'b0;
						end else if (st_reg.pend.act) begin
							st_next.nt = NT_G2; // RULE3
							st_next.t2_run = 1'b0;
						end
					end
					default: begin
						st_next.nt = NT_G0;
					end
				endcase
			end
			if (NT_MODE) begin
				st_next.te = TE_F0;
			end else if (st_reg.te == TE_F0) begin
				if (st_reg.pend.rel) begin
					st_next.te = TE_F2; // RULE12
				end
			end else if (RX.lost && (st_reg.te == TE_F6 || st_reg.te == TE_F7)) begin
				st_next.te = TE_F8; // RULE20
			end else if (RX.info4_sync && st_reg.te != TE_F7) begin
				st_next.te = TE_F7; // RULE19
			end else if (RX.info2_sync && st_reg.te != TE_F6) begin
				st_next.te = TE_F6; // RULE18
			end else if (RX.info0 && (st_reg.te == TE_F2 || st_reg.te == TE_F6 || st_reg.te == TE_F7
					|| st_reg.te == TE_F8)) begin
				st_next.te = TE_F3; // RULE17
			end else if (RX.any_sig && st_reg.te == TE_F4) begin
				st_next.te = TE_F5; // RULE14
			end else if (st_reg.pend.t3_exp && (st_reg.te == TE_F4 || st_reg.te == TE_F5
					|| st_reg.te == TE_F6)) begin
				st_next.te = TE_F3; // RULE16
			end else if (st_reg.pend.act && st_reg.te == TE_F3) begin
				if (RX.any_sig) begin
					st_next.te = TE_F5; // RULE14
				end else if (RX.info0) begin
					st_next.te = TE_F4; // RULE15
				end
			end
			if (NT_MODE) begin
				unique case (st_next.nt)
					NT_G2: st_next.info = INFO_2; // RULE2
					NT_G3: st_next.info = INFO_4; // RULE2
					default: st_next.info = INFO_0; // RULE2
				endcase
			end else begin
				unique case (st_next.te)
					TE_F4: st_next.info = INFO_1; // RULE13
					TE_F6, TE_F7: st_next.info = INFO_3; // RULE13
					default: st_next.info = INFO_0; // RULE13
				endcase
			end
			st_next.qs_cnt = (st_reg.qs_cnt == 3'(QS_PERIOD - 1)) ? 3'h0 : st_reg.qs_cnt + 3'h1;
			// FA toward the network carries Q only in the first of each five frames
			st_next.q_slot = !NT_MODE && QS_EN && st_next.qs_cnt == 3'h0; // RULE21
			st_next.fa = st_next.q_slot ? Q_IN : 1'b0; // RULE21
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign TX_INFO = st_reg.info;
	assign NT_STATE = st_reg.nt;
	assign TE_STATE = st_reg.te;
	assign T2_RUN = st_reg.t2_run;
	assign FRAME_TICK = tick;
	assign Q_SLOT = st_reg.q_slot;
	assign FA_TX = st_reg.fa;
	assign B_LINE_TX = st_reg.b_tx;
	assign B_RX_BYTE = st_reg.b_rx;

	// Frames counted since T2 started, read only by the checks
	logic [T2_W:0] h_t2;
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			h_t2 <= '0;
		end else if (!st_reg.t2_run) begin
			h_t2 <= '0;
		end else if (tick) begin
			h_t2 <= h_t2 + 1'b1;
		end
	end

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	chk_nt_release: assert property (st_reg.nt != NT_G0 && $past(st_reg.nt) == NT_G0 // RULE1
		|-> $past(tick) && $past(st_reg.pend.rel))
		else $error("NT left G0 without release");
	chk_nt_info_map: assert property (NT_MODE && $past(tick) && $past(NT_MODE) // RULE2
		|-> TX_INFO == (st_reg.nt == NT_G2 ? INFO_2 : st_reg.nt == NT_G3 ? INFO_4 : INFO_0))
		else $error("NT sends wrong INFO");
	chk_nt_activate: assert property (tick && NT_MODE && st_reg.nt == NT_G1 && st_reg.pend.act // RULE3
		|=> st_reg.nt == NT_G2)
		else $error("activate in G1 did not reach G2");
	chk_nt_deact: assert property (tick && NT_MODE && st_reg.pend.deact // RULE4
		&& (st_reg.nt == NT_G2 || st_reg.nt == NT_G3) |=> st_reg.nt == NT_G4 && T2_RUN)
		else $error("deactivate did not start T2 in G4");
	chk_t2_length: assert property (tick && t2_exp |-> h_t2 == (T2_W + 1)'(T2_LEN - 1)) // RULE5
		else $error("T2 expired after wrong frame count");
	chk_t2_expiry: assert property (tick && NT_MODE && t2_exp && st_reg.nt == NT_G4 // RULE6
		|=> st_reg.nt == NT_G1 && !T2_RUN)
		else $error("T2 expiry did not give G1");
	chk_nt_lost: assert property (tick && NT_MODE && st_reg.nt == NT_G3 && !st_reg.pend.deact // RULE10
		&& (RX.lost || RX.info0) |=> st_reg.nt == NT_G2)
		else $error("G3 did not fall back to G2");
	chk_te_info4: assert property (tick && !NT_MODE && RX.info4_sync && !RX.lost // RULE19
		&& st_reg.te != TE_F0 |=> st_reg.te == TE_F7 ##1 TX_INFO == INFO_3 [*2])
		else $error("INFO4 sync did not activate TE");
	chk_te_lost: assert property (tick && !NT_MODE && RX.lost // RULE20
		&& (st_reg.te == TE_F6 || st_reg.te == TE_F7) |=> st_reg.te == TE_F8 && TX_INFO == INFO_0)
		else $error("sync loss did not give F8");
	chk_frame_only: assert property (!tick |=> $stable(st_reg.nt) && $stable(st_reg.te) // RULE23
		&& $stable(TX_INFO))
		else $error("state moved between frames");
	chk_q_slot: assert property (tick && !NT_MODE && QS_EN && st_reg.qs_cnt == 3'(QS_PERIOD - 1) // RULE21
		|=> Q_SLOT && FA_TX == $past(Q_IN))
		else $error("Q slot missed");
	chk_b_order: assert property (B_LINE_TX[7] == ($past(B_HDLC) ? $past(B_TX_BYTE[0]) // RULE22
		: $past(B_TX_BYTE[7])) && B_RX_BYTE[0] == ($past(B_HDLC) ? $past(B_LINE_RX[7]) : $past(B_LINE_RX[0])))
		else $error("B bit order wrong");

	// Further NT machine checks
	// Guards mirror the branch order inside each state
	chk_nt_g0_hold: assert property (tick && NT_MODE && st_reg.nt == NT_G0 && !st_reg.pend.rel // RULE1
		|=> st_reg.nt == NT_G0)
		else $error("NT left G0 while held");
	chk_nt_g3_act: assert property (tick && NT_MODE && st_reg.nt == NT_G3 && st_reg.pend.act // RULE3
		&& !st_reg.pend.deact && !RX.info0 && !RX.lost |=> st_reg.nt == NT_G3)
		else $error("activate moved NT out of G3");
	chk_nt_g4_act: assert property (tick && NT_MODE && st_reg.nt == NT_G4 && st_reg.pend.act && !t2_exp // RULE3
		&& !RX.info0 |=> st_reg.nt == NT_G2 && !T2_RUN)
		else $error("activate in G4 did not reach G2");
	chk_nt_info1: assert property (tick && NT_MODE && st_reg.nt == NT_G1 && RX.info1 // RULE8
		|=> st_reg.nt == NT_G2 && TX_INFO == INFO_2)
		else $error("INFO1 in G1 did not reach G2");
	chk_nt_info3: assert property (tick && NT_MODE && st_reg.nt == NT_G2 && RX.info3 && !st_reg.pend.deact // RULE9
		|=> st_reg.nt == NT_G3 && TX_INFO == INFO_4)
		else $error("INFO3 in G2 did not reach G3");
	chk_nt_g4_info0: assert property (tick && NT_MODE && st_reg.nt == NT_G4 && RX.info0 // RULE7
		|=> st_reg.nt == NT_G1 && !T2_RUN)
		else $error("INFO0 in G4 did not reach G1");
	chk_t2_only_g4: assert property (T2_RUN // RULE4
		|-> st_reg.nt == NT_G4)
		else $error("T2 running outside G4");
	chk_t2_hold: assert property (tick && NT_MODE && st_reg.nt == NT_G4 && T2_RUN && !t2_exp && !RX.info0 // RULE5
		&& !st_reg.pend.act |=> st_reg.nt == NT_G4 && T2_RUN)
		else $error("T2 ended early");
	chk_nt_idle_te: assert property ($past(tick) && !$past(NT_MODE) // RULE1
		|-> st_reg.nt == NT_G0 && !T2_RUN)
		else $error("NT machine not held in G0 in TE mode");
	chk_q_nt: assert property ($past(tick) && $past(NT_MODE) // RULE21
		|-> !Q_SLOT && !FA_TX)
		else $error("Q slot used in NT mode");

	// Further TE machine checks
	// Exclusions follow the priority order of the TE chain above
	chk_te_f0_hold: assert property (tick && !NT_MODE && st_reg.te == TE_F0 && !st_reg.pend.rel // RULE12
		|=> st_reg.te == TE_F0)
		else $error("TE left F0 while held");
	chk_te_release: assert property (st_reg.te != TE_F0 && $past(st_reg.te) == TE_F0 // RULE12
		|-> $past(tick) && $past(st_reg.pend.rel) && !$past(NT_MODE))
		else $error("TE left F0 without release");
	chk_te_info_map: assert property (!NT_MODE && $past(tick) && !$past(NT_MODE) |-> TX_INFO == // RULE13
		(st_reg.te == TE_F4 ? INFO_1 : (st_reg.te == TE_F6 || st_reg.te == TE_F7) ? INFO_3 : INFO_0))
		else $error("TE sends wrong INFO");
	chk_te_act_info0: assert property (tick && !NT_MODE && st_reg.te == TE_F3 && st_reg.pend.act && RX.info0 // RULE15
		&& !RX.any_sig && !RX.info2_sync && !RX.info4_sync |=> st_reg.te == TE_F4 && TX_INFO == INFO_1)
		else $error("activate with INFO0 did not reach F4");
	chk_te_act_sig: assert property (tick && !NT_MODE && st_reg.te == TE_F3 && st_reg.pend.act && RX.any_sig // RULE14
		&& !RX.info2_sync && !RX.info4_sync |=> st_reg.te == TE_F5)
		else $error("activate with signal did not reach F5");
	chk_te_any_sig: assert property (tick && !NT_MODE && st_reg.te == TE_F4 && RX.any_sig // RULE14
		&& !RX.info2_sync && !RX.info4_sync |=> st_reg.te == TE_F5)
		else $error("signal in F4 did not reach F5");
	chk_te_t3: assert property (tick && !NT_MODE && st_reg.te == TE_F5 && st_reg.pend.t3_exp // RULE16
		&& !RX.info2_sync && !RX.info4_sync |=> st_reg.te == TE_F3)
		else $error("T3 expiry did not give F3");
	chk_te_info2: assert property (tick && !NT_MODE && RX.info2_sync && !RX.info4_sync && !RX.lost // RULE18
		&& st_reg.te != TE_F0 && st_reg.te != TE_F6 |=> st_reg.te == TE_F6 && TX_INFO == INFO_3)
		else $error("INFO2 sync did not give F6");
	chk_te_info0: assert property (tick && !NT_MODE && RX.info0 && !RX.info2_sync && !RX.info4_sync // RULE17
		&& (st_reg.te == TE_F2 || st_reg.te == TE_F8) |=> st_reg.te == TE_F3)
		else $error("INFO0 did not give F3");
	chk_te_idle_nt: assert property ($past(tick) && $past(NT_MODE) // RULE12
		|-> st_reg.te == TE_F0)
		else $error("TE machine not held in F0 in NT mode");

	// Frame pacing, command latching and Q enable
	chk_tick_gap: assert property (tick // RULE23
		|=> !tick)
		else $error("frame ticks too close");
	chk_pend_clear: assert property (tick && !CMD.act // RULE23
		|=> !st_reg.pend.act)
		else $error("activate request outlived its frame");
	chk_q_off: assert property (tick && !QS_EN // RULE21
		|=> !Q_SLOT && !FA_TX)
		else $error("Q slot without Q enable");

	// Per-bit order check; the edge after reset is skipped because the vectors still hold zeros
	generate
		for (i = 0; i < 8; i++) begin : g_b_chk
			chk_b_tx_bit: assert property ($past(RST_B) |-> B_LINE_TX[7 - i] == ($past(B_HDLC) // RULE22
				? $past(B_TX_BYTE[i]) : $past(B_TX_BYTE[7 - i])))
				else $error("B transmit bit out of order");
			chk_b_rx_bit: assert property ($past(RST_B) |-> B_RX_BYTE[i] == ($past(B_HDLC) // RULE22
				? $past(B_LINE_RX[7 - i]) : $past(B_LINE_RX[i])))
				else $error("B receive bit out of order");
		end
	endgenerate
endmodule : stl_act_fsm

// ---- testbench/stl_line_peer.sv ----
// Remote S/T peer: what the far end sends, seen as receiver status levels
`timescale 1ns/100ps
module stl_line_peer import stl_pkg::*; (
	input wire logic [2:0] SEND,
	input wire logic SYNC_LOST,
	output stl_rx_t RX
);
	// Code 7 is a signal not yet identified as INFO 2 or INFO 4
	always_comb begin
		RX.info0 = SEND == 3'h0;
		RX.info1 = SEND == 3'h1;
		RX.info3 = SEND == 3'h3;
		RX.any_sig = SEND == 3'h7;
		RX.info2_sync = SEND == 3'h2;
		RX.info4_sync = SEND == 3'h4;
		RX.lost = SYNC_LOST;
	end
endmodule : stl_line_peer

// ---- testbench/test_stl_act_fsm.sv ----
// Self-checking bench for the S/T activation machines, FA/Q slot and B bit order
`timescale 1ns/100ps
module test_stl_act_fsm import stl_pkg::*; ;
	logic mclk, rst_b, nt_mode, qs_en, q_in, b_hdlc, lost, t2_run, frame_tick, q_slot, fa_tx;
	logic [2:0] send;
	logic [7:0] b_tx_byte, b_line_rx, b_line_tx, b_rx_byte;
	stl_cmd_t cmd;
	stl_rx_t rx;
	stl_info_t tx_info;
	stl_nt_t nt_state;
	stl_te_t te_state;
	int n_mismatch = 0;
	int num_checks = 0;
	stl_line_peer peer (.SEND(send), .SYNC_LOST(lost), .RX(rx));
	// Short frame and T2 keep the run brief; expectations follow these values
	stl_act_fsm #(.FRAME_CYCLES(8), .T2_LEN(4)) uut (.MCLK(mclk), .RST_B(rst_b), .NT_MODE(nt_mode),
		.CMD(cmd), .RX(rx), .QS_EN(qs_en), .Q_IN(q_in), .B_HDLC(b_hdlc), .B_TX_BYTE(b_tx_byte),
		.B_LINE_RX(b_line_rx), .TX_INFO(tx_info), .NT_STATE(nt_state), .TE_STATE(te_state),
		.T2_RUN(t2_run), .FRAME_TICK(frame_tick), .Q_SLOT(q_slot), .FA_TX(fa_tx),
		.B_LINE_TX(b_line_tx), .B_RX_BYTE(b_rx_byte));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	// Returns at the falling edge just after the next frame tick
	task automatic tick;
		int i;
		i = 0;
		while (frame_tick !== 1'b1 && i < 40) begin
			@(negedge mclk);
			i++;
		end
		if (i == 40) begin
			n_mismatch++;
			give_verdict();
		end
		@(negedge mclk);
	endtask : tick
	// Command issued right after a tick so it is never caught on a tick edge
	task automatic frm(input stl_cmd_t c, input logic [2:0] s, input logic l);
		tick();
		cmd = c;
		send = s;
		lost = l;
		@(negedge mclk);
		cmd = '0;
		tick();
	endtask : frm
	task automatic nt(input stl_nt_t s, input stl_info_t f);
		chk(nt_state, s, "nt state");
		chk(tx_info, f, "nt info");
	endtask : nt
	task automatic te(input stl_te_t s, input stl_info_t f);
		chk(te_state, s, "te state");
		chk(tx_info, f, "te info");
	endtask : te
	task automatic rst(input logic m);
		nt_mode = m;
		rst_b = 1'b0;
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
	endtask : rst
	task automatic nt_walk;
		rst(1'b1);
		frm(4'h0, 3'h1, 1'b0);
		nt(NT_G0, INFO_0);
		frm(4'h8, 3'h0, 1'b0);
		nt(NT_G2, INFO_2);
		frm(4'h0, 3'h3, 1'b0);
		nt(NT_G3, INFO_4);
		frm(4'h4, 3'h3, 1'b0);
		nt(NT_G3, INFO_4);
		frm(4'h0, 3'h3, 1'b1);
		nt(NT_G2, INFO_2);
		frm(4'h0, 3'h3, 1'b0);
		frm(4'h0, 3'h0, 1'b0);
		nt(NT_G2, INFO_2);
		frm(4'h2, 3'h1, 1'b0);
		nt(NT_G4, INFO_0);
		chk(t2_run, 1'b1, "t2 run");
		repeat (3) begin
			tick();
			chk(nt_state, NT_G4, "t2 early");
		end
		tick();
		nt(NT_G1, INFO_0);
		chk(t2_run, 1'b0, "t2 stop");
		tick();
		nt(NT_G2, INFO_2);
		frm(4'h2, 3'h1, 1'b0);
		frm(4'h4, 3'h1, 1'b0);
		nt(NT_G2, INFO_2);
		frm(4'h2, 3'h1, 1'b0);
		frm(4'h0, 3'h0, 1'b0);
		nt(NT_G1, INFO_0);
		frm(4'h4, 3'h0, 1'b0);
		nt(NT_G2, INFO_2);
	endtask : nt_walk
	task automatic te_walk;
		rst(1'b0);
		frm(4'h0, 3'h0, 1'b0);
		te(TE_F0, INFO_0);
		frm(4'h8, 3'h0, 1'b0);
		te(TE_F2, INFO_0);
		tick();
		te(TE_F3, INFO_0);
		frm(4'h4, 3'h0, 1'b0);
		te(TE_F4, INFO_1);
		frm(4'h0, 3'h7, 1'b0);
		te(TE_F5, INFO_0);
		frm(4'h1, 3'h7, 1'b0);
		te(TE_F3, INFO_0);
		frm(4'h4, 3'h7, 1'b0);
		te(TE_F5, INFO_0);
		frm(4'h0, 3'h2, 1'b0);
		te(TE_F6, INFO_3);
		frm(4'h0, 3'h4, 1'b0);
		te(TE_F7, INFO_3);
		frm(4'h0, 3'h0, 1'b1);
		te(TE_F8, INFO_0);
		frm(4'h0, 3'h0, 1'b0);
		te(TE_F3, INFO_0);
	endtask : te_walk
	task automatic q_and_b;
		int n;
		n = 0;
		qs_en = 1'b1;
		q_in = 1'b1;
		repeat (10) begin
			q_in = ~q_in;
			tick();
			n += q_slot;
			chk(fa_tx, q_slot & q_in, "fa bit");
		end
		chk(n, 2, "q slots");
		b_hdlc = 1'b1;
		b_tx_byte = 8'h1c;
		b_line_rx = 8'h1c;
		@(negedge mclk);
		chk(b_line_tx, 8'h38, "hdlc tx");
		chk(b_rx_byte, 8'h38, "hdlc rx");
		b_hdlc = 1'b0;
		@(negedge mclk);
		chk(b_line_tx, 8'h1c, "pcm tx");
		chk(b_rx_byte, 8'h1c, "pcm rx");
	endtask : q_and_b
	initial begin
		{qs_en, q_in, b_hdlc, lost, send, b_tx_byte, b_line_rx} = '0;
		cmd = '0;
		nt_walk();
		te_walk();
		q_and_b();
		give_verdict();
	end
endmodule : test_stl_act_fsm
